// file: inc/sfcd_pkg.sv
/*
  Constants, register map and types for the sample clock conditioning
  block: clock divider, alignment resync and duty fix loop control.
  Assumes one 10 MHz reference clock that stands for the incoming
  sample clock, and a simple byte-wide register port.
*/
// Function
// RULE_01: The block divides the incoming clock by any integer from 1 to 8 to make the conversion clock.
// RULE_02: Any divide ratio other than 1 forces the duty fix loop on whatever its enable bit says.
// RULE_03: Bits 1 and 2 of sync_control pick resync on every alignment pulse or only on the first one after a write.
// RULE_04: An accepted alignment pulse returns the divider to its initial state.
// RULE_05: A locked duty fix loop rebuilds the falling edge for 50% duty and leaves the rising edge in place; odd ratios run high one cycle longer than low.
// RULE_06: Below about 20 MHz the loop does not work and the timing follows the input duty cycle.
// RULE_07: After any clock rate change the loop is bypassed and unlocked for 1.5 to 5 us before relocking.
// RULE_08: The controlling side should disable the loop when the rate changes on the fly and enable it otherwise.
// RULE_09: Each new sample is taken on the rising edge of the conversion clock.
// RULE_10: The alignment pulse is sampled on the undivided clock and only its rising edge acts.
package sfcd_pkg;

  // ------------------------------------------------------------------
  // Register port
  // ------------------------------------------------------------------
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;

  localparam logic [ADDR_W-1:0] OFF_DUTY_FIX     = 13'h009;
  localparam logic [ADDR_W-1:0] OFF_CLOCK_DIVIDE = 13'h00b;
  localparam logic [ADDR_W-1:0] OFF_SYNC_CONTROL = 13'h100;

  // duty_fix fields
  localparam int DUTY_EN_BIT   = 0;
  localparam int DUTY_LOCK_BIT = 1;
  localparam int DUTY_ACT_BIT  = 2;
  // clock_divide fields: ratio minus one in the low three bits
  localparam int DIV_LSB = 0;
  localparam int DIV_W   = 3;
  // sync_control fields
  localparam int SYNC_EN_BIT    = 1;
  localparam int SYNC_ONCE_BIT  = 2;
  localparam int SYNC_ARMED_BIT = 3;

  localparam logic [DATA_W-1:0] RST_DUTY_FIX     = 8'h01;
  localparam logic [DATA_W-1:0] RST_CLOCK_DIVIDE = 8'h00;
  localparam logic [DATA_W-1:0] RST_SYNC_CONTROL = 8'h00;
  localparam logic [DATA_W-1:0] UNMAPPED_READ    = 8'h00;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int REF_CLK_KHZ   = 10000;
  localparam int RELOCK_MIN_NS = 1500;
  localparam int RELOCK_MAX_NS = 5000;
  // Least time rounds up, longest rounds down
  localparam int RELOCK_MIN_CYC =
    (RELOCK_MIN_NS * REF_CLK_KHZ + 999999) / 1000000;
  localparam int RELOCK_MAX_CYC =
    (RELOCK_MAX_NS * REF_CLK_KHZ) / 1000000;
  localparam int RELOCK_CNT_W = 6;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    SFCD_LOOP_OFF    = 3'b001,
    SFCD_LOOP_RELOCK = 3'b010,
    SFCD_LOOP_LOCKED = 3'b100
  } sfcd_loop_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              wr;
    logic              rd;
    logic [DATA_W-1:0] wdata;
  } sfcd_reg_req_t;

endpackage

// file: verification/sfcd_properties.sv
/* Checker for the sfcd_clock_ctrl ports.
   Assumes it is bound to that module. */
`timescale 1ns/10ps
module sfcd_properties #(
  parameter int RELOCK_CYC = 15
) (
  input wire logic                        ref_clk,
  input wire logic                        rst,
  input wire sfcd_pkg::sfcd_reg_req_t     reg_req,
  input wire logic [sfcd_pkg::DATA_W-1:0] reg_rdata,
  input wire logic                        reg_rvalid,
  input wire logic                        align_pulse,
  input wire logic                        rate_low,
  input wire logic                        rate_change,
  input wire logic                        conv_clk,
  input wire logic                        sample_en,
  input wire logic                        loop_locked,
  input wire logic                        align_done
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [3:0] div_n;
  logic [3:0] gap;
  logic [1:0] settle;
  logic       seen;
  logic       sync_en;
  logic [5:0] low_cnt;
  wire wr_div = reg_req.wr && reg_req.addr == sfcd_pkg::OFF_CLOCK_DIVIDE;
  wire wr_sync = reg_req.wr && reg_req.addr == sfcd_pkg::OFF_SYNC_CONTROL;
  // Period is trusted only after a restart has settled
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      div_n <= 4'h1;
      gap <= 4'h0;
      settle <= 2'h0;
      seen <= 1'b0;
      sync_en <= 1'b0;
      low_cnt <= 6'h00;
    end else begin
      if (wr_div) div_n <= {1'b0, reg_req.wdata[2:0]} + 4'h1;
      if (wr_sync) sync_en <= reg_req.wdata[sfcd_pkg::SYNC_EN_BIT];
      gap <= sample_en ? 4'h1 : gap + 4'h1;
      if (wr_div || align_done) settle <= 2'h3;
      else if (settle != 2'h0) settle <= settle - 2'h1;
      if (wr_div || align_done) seen <= 1'b0;
      else if (sample_en) seen <= (settle == 2'h0);
      low_cnt <= loop_locked ? 6'h00 : low_cnt + {5'h00, low_cnt != 6'h3f};
    end
  end
  a_read_answer: assert property (reg_req.rd |=> reg_rvalid)
    else $error("read not answered");
  a_no_stray: assert property (reg_rvalid |-> $past(reg_req.rd))
    else $error("answer without read");
  a_align_edge: assert property (align_done |-> $past(align_pulse) && !$past(align_pulse, 2))
    else $error("align not on rising edge");
  a_align_enable: assert property (align_done |-> $past(sync_en))
    else $error("align while resync off");
  a_align_restart: assert property (align_done |=> sample_en)
    else $error("divider not restarted");
  a_sample_period: assert property (sample_en && seen |-> gap == div_n)
    else $error("wrong divide period");
  a_lock_wait: assert property ($rose(loop_locked) |-> low_cnt >= RELOCK_CYC)
    else $error("relock too early");
  a_slow_unlock: assert property (rate_low |-> ##2 !loop_locked)
    else $error("locked at low rate");
  a_step_unlock: assert property (rate_change |-> ##2 !loop_locked)
    else $error("locked after rate step");
  a_rise_kept: assert property (sample_en |-> conv_clk)
    else $error("sampling edge moved");
  c_align: cover property (align_done);
  c_relock: cover property ($rose(loop_locked));
  c_div8: cover property (sample_en && seen && div_n == 4'h8);
endmodule

// file: verification/sfcd_src_model.sv
/* Sample clock rate flags and alignment pulse source.
   Assumes the bench calls its tasks. */
`timescale 1ns/10ps
module sfcd_src_model (
  input  wire logic ref_clk,
  output logic      align_pulse,
  output logic      rate_low,
  output logic      rate_change
);
  initial begin
    align_pulse = 1'b0;
    rate_low = 1'b0;
    rate_change = 1'b0;
  end
  // Pulse, then low cycles so pulses stay apart
  task automatic align(input int len);
    @(negedge ref_clk);
    align_pulse = 1'b1;
    repeat (len) @(negedge ref_clk);
    align_pulse = 1'b0;
    repeat (2) @(negedge ref_clk);
  endtask
  // Single step, then the rate holds still
  task automatic step();
    @(negedge ref_clk);
    rate_change = 1'b1;
    @(negedge ref_clk);
    rate_change = 1'b0;
  endtask
  task automatic slow(input logic v);
    @(negedge ref_clk);
    rate_low = v;
  endtask
endmodule

// file: verification/test_sample_clock_divider_sync.sv
/* Bench for sfcd_clock_ctrl with source model and checker.
   Assumes a 10 MHz ref_clk. */
`timescale 1ns/10ps
module test_sample_clock_divider_sync;
  localparam logic [12:0] DUTY = sfcd_pkg::OFF_DUTY_FIX;
  localparam logic [12:0] DIV  = sfcd_pkg::OFF_CLOCK_DIVIDE;
  localparam logic [12:0] SYNC = sfcd_pkg::OFF_SYNC_CONTROL;
  localparam int          LMIN = sfcd_pkg::RELOCK_MIN_CYC;
  logic                    ref_clk = 1'b0;
  logic                    rst = 1'b1;
  sfcd_pkg::sfcd_reg_req_t reg_req = '0;
  logic [7:0]              reg_rdata;
  logic                    reg_rvalid;
  logic                    align_pulse;
  logic                    rate_low;
  logic                    rate_change;
  logic                    conv_clk;
  logic                    sample_en;
  logic                    loop_locked;
  logic                    align_done;
  int                      n_errors = 0;
  int                      check_count = 0;
  int                      n_align = 0;
  int                      cyc = 0;
  int                      p;
  always #50 ref_clk = ~ref_clk;
  always @(negedge ref_clk) n_align += int'(align_done === 1'b1);
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      $display("unexpected at %0t: timeout", $time);
      final_report();
    end
  end
  sfcd_clock_ctrl #(.RELOCK_CYC(LMIN)) sfcd_clock_ctrl_inst (
    .ref_clk(ref_clk), .rst(rst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .align_pulse(align_pulse), .rate_low(rate_low),
    .rate_change(rate_change), .conv_clk(conv_clk),
    .sample_en(sample_en), .loop_locked(loop_locked),
    .align_done(align_done));
  sfcd_src_model sfcd_src_model_inst (.ref_clk(ref_clk),
    .align_pulse(align_pulse), .rate_low(rate_low),
    .rate_change(rate_change));
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s %h not %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_req.addr = a;
    reg_req.wdata = d;
    reg_req.wr = 1'b1;
    @(negedge ref_clk);
    reg_req.wr = 1'b0;
  endtask
  task automatic rdchk(input logic [12:0] a, input logic [7:0] m, exp,
                       input string what);
    @(negedge ref_clk);
    reg_req.addr = a;
    reg_req.rd = 1'b1;
    @(negedge ref_clk);
    reg_req.rd = 1'b0;
    chk({7'h00, reg_rvalid}, 8'h01, "answer");
    chk(reg_rdata & m, exp, what);
  endtask
  task automatic period(output int n);
    n = 0;
    while (sample_en !== 1'b1 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (sample_en !== 1'b1 && n < 20);
  endtask
  task automatic al(input int len, input logic [7:0] exp, input string what);
    int a0;
    a0 = n_align;
    sfcd_src_model_inst.align(len);
    chk(8'(n_align - a0), exp, what);
  endtask
  task automatic highs(input logic [7:0] exp, input string what);
    int h;
    h = 0;
    repeat (10) begin
      @(negedge ref_clk);
      h += int'(conv_clk === 1'b1);
    end
    chk(8'(h), exp, what);
  endtask
  // Waits for the lock to drop, if held, and come back
  task automatic lock_chk(input string what);
    int n;
    bit gone;
    n = 0;
    gone = loop_locked !== 1'b1;
    while (!(gone && loop_locked === 1'b1) && n < 100) begin
      @(negedge ref_clk);
      n++;
      gone |= loop_locked !== 1'b1;
    end
    chk(8'(n >= LMIN && n <= sfcd_pkg::RELOCK_MAX_CYC), 8'h01, what);
  endtask
  initial begin
    repeat (8) @(negedge ref_clk);
    rst = 1'b0;
    rdchk(DIV, 8'hff, 8'h00, "div reset");
    rdchk(SYNC, 8'hff, 8'h00, "sync reset");
    rdchk(DUTY, 8'h01, 8'h01, "duty reset");
    wr(13'h0ff, 8'h5a);
    rdchk(13'h0ff, 8'hff, sfcd_pkg::UNMAPPED_READ, "unmapped");
    $display("done: reset values");
    wr(DUTY, 8'h00);
    for (int n = 8; n >= 1; n--) begin
      wr(DIV, 8'(n - 1));
      // Three periods so the checker also sees a settled one
      repeat (3) period(p);
      chk(8'(p), 8'(n), "period");
      rdchk(DUTY, 8'h04, (n > 1) ? 8'h04 : 8'h00, "forced");
    end
    $display("done: divider");
    wr(DIV, 8'h03);
    al(5, 8'h00, "resync off");
    wr(SYNC, 8'h02);
    al(5, 8'h01, "long pulse");
    al(1, 8'h01, "every pulse");
    wr(SYNC, 8'h06);
    rdchk(SYNC, 8'hff, 8'h0e, "armed");
    al(2, 8'h01, "first pulse");
    al(2, 8'h00, "later pulse");
    rdchk(SYNC, 8'hff, 8'h06, "disarmed");
    wr(SYNC, 8'h06);
    al(2, 8'h01, "rearmed");
    $display("done: alignment");
    wr(DUTY, 8'h01);
    wr(DIV, 8'h04);
    lock_chk("ratio relock");
    highs(8'h06, "locked duty");
    sfcd_src_model_inst.slow(1'b1);
    repeat (3) @(negedge ref_clk);
    chk({7'h00, loop_locked}, 8'h00, "slow unlock");
    highs(8'h02, "input duty");
    sfcd_src_model_inst.slow(1'b0);
    lock_chk("slow relock");
    sfcd_src_model_inst.step();
    lock_chk("step relock");
    $display("done: duty loop");
    final_report();
  end
endmodule
bind sfcd_clock_ctrl sfcd_properties #(.RELOCK_CYC(RELOCK_CYC))
  sfcd_properties_inst (.ref_clk(ref_clk), .rst(rst), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .align_pulse(align_pulse),
  .rate_low(rate_low), .rate_change(rate_change), .conv_clk(conv_clk),
  .sample_en(sample_en), .loop_locked(loop_locked), .align_done(align_done));

// file: verilog/sfcd_clock_ctrl.sv
/*
  Sample clock conditioning: register file, divider, alignment resync
  and duty fix loop state with relock timing.
  Assumes inputs synchronous to ref_clk; ref_clk stands for the
  undivided sample clock; rate_low and rate_change come from the clock
  receiver that measures the incoming rate.
*/
`timescale 1ns/10ps
module sfcd_clock_ctrl #(
  parameter int DIV_W        = sfcd_pkg::DIV_W,
  parameter int RELOCK_CYC   = sfcd_pkg::RELOCK_MIN_CYC
) (
  input  wire logic                        ref_clk,
  input  wire logic                        rst,
  input  wire sfcd_pkg::sfcd_reg_req_t     reg_req,
  output logic      [sfcd_pkg::DATA_W-1:0] reg_rdata,
  output logic                             reg_rvalid,
  input  wire logic                        align_pulse,
  input  wire logic                        rate_low,
  input  wire logic                        rate_change,
  output logic                             conv_clk,
  output logic                             sample_en,
  output logic                             loop_locked,
  output logic                             align_done
);

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  logic [sfcd_pkg::DATA_W-1:0] duty_fix;
  logic [sfcd_pkg::DATA_W-1:0] clock_divide;
  logic [sfcd_pkg::DATA_W-1:0] sync_control;
  logic                        sync_armed;

  wire sel_duty = (reg_req.addr == sfcd_pkg::OFF_DUTY_FIX);
  wire sel_div  = (reg_req.addr == sfcd_pkg::OFF_CLOCK_DIVIDE);
  wire sel_sync = (reg_req.addr == sfcd_pkg::OFF_SYNC_CONTROL);
  wire wr_duty  = reg_req.wr && sel_duty;
  wire wr_div   = reg_req.wr && sel_div;
  wire wr_sync  = reg_req.wr && sel_sync;

  wire [DIV_W-1:0] ratio_m1 =
    clock_divide[sfcd_pkg::DIV_LSB +: DIV_W];
  wire [DIV_W-1:0] new_ratio_m1 =
    reg_req.wdata[sfcd_pkg::DIV_LSB +: DIV_W];
  // A new ratio changes the internal clock rate
  wire ratio_changed = wr_div && (new_ratio_m1 != ratio_m1);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      duty_fix     <= sfcd_pkg::RST_DUTY_FIX;
      clock_divide <= sfcd_pkg::RST_CLOCK_DIVIDE;
      sync_control <= sfcd_pkg::RST_SYNC_CONTROL;
    end else begin
      if (wr_duty) begin
        duty_fix <= reg_req.wdata;
      end
      if (wr_div) begin
        clock_divide <= reg_req.wdata;
      end
      if (wr_sync) begin
        sync_control <= reg_req.wdata;
      end
    end
  end

  // ------------------------------------------------------------------
  // Alignment pulse
  // ------------------------------------------------------------------
  logic align_q;
  wire  align_edge = align_pulse && !align_q; // RULE_10
  wire  sync_en    = sync_control[sfcd_pkg::SYNC_EN_BIT];
  wire  sync_once  = sync_control[sfcd_pkg::SYNC_ONCE_BIT];
  wire  align_take = align_edge && sync_en &&
                     (!sync_once || sync_armed); // RULE_03
  // Re-arm on write wins over the disarm of the same cycle
  wire  next_armed = wr_sync ? 1'b1 :
                     (align_take ? 1'b0 : sync_armed); // RULE_03

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      align_q    <= 1'b0;
      sync_armed <= 1'b0;
      align_done <= 1'b0;
    end else begin
      align_q    <= align_pulse; // RULE_10
      sync_armed <= next_armed;
      align_done <= align_take;
    end
  end

  // ------------------------------------------------------------------
  // Divider
  // ------------------------------------------------------------------
  logic [DIV_W-1:0] phase;
  logic             rise;

  sfcd_div #(
    .DIV_W (DIV_W)
  ) u_div (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .ratio_m1 (ratio_m1),
    .restart  (align_take || ratio_changed), // RULE_04
    .phase    (phase),
    .rise     (rise)
  );

  // ------------------------------------------------------------------
  // Duty fix loop
  // ------------------------------------------------------------------
  sfcd_pkg::sfcd_loop_t       loop_st;
  sfcd_pkg::sfcd_loop_t       next_loop_st;
  logic [sfcd_pkg::RELOCK_CNT_W-1:0] relock_cnt;
  logic [sfcd_pkg::RELOCK_CNT_W-1:0] next_relock_cnt;

  wire loop_active = duty_fix[sfcd_pkg::DUTY_EN_BIT] ||
                     (ratio_m1 != '0); // RULE_02
  wire rate_step   = rate_change || ratio_changed; // RULE_07
  wire relock_done = (relock_cnt ==
    sfcd_pkg::RELOCK_CNT_W'(RELOCK_CYC - 1)); // RULE_07

  always_comb begin
    next_loop_st    = loop_st;
    next_relock_cnt = '0;
    case (loop_st)
      sfcd_pkg::SFCD_LOOP_OFF: begin
        if (loop_active) begin
          next_loop_st = sfcd_pkg::SFCD_LOOP_RELOCK;
        end
      end
      sfcd_pkg::SFCD_LOOP_RELOCK: begin
        if (!loop_active) begin
          next_loop_st = sfcd_pkg::SFCD_LOOP_OFF;
        end else if (rate_step || rate_low) begin
          next_relock_cnt = '0; // RULE_06
        end else if (relock_done) begin
          next_loop_st = sfcd_pkg::SFCD_LOOP_LOCKED; // RULE_07
        end else begin
          next_relock_cnt =
            sfcd_pkg::RELOCK_CNT_W'(relock_cnt + 1'b1);
        end
      end
      sfcd_pkg::SFCD_LOOP_LOCKED: begin
        if (!loop_active) begin
          next_loop_st = sfcd_pkg::SFCD_LOOP_OFF;
        end else if (rate_step || rate_low) begin
          next_loop_st = sfcd_pkg::SFCD_LOOP_RELOCK; // RULE_07
        end
      end
      default: begin
        next_loop_st = sfcd_pkg::SFCD_LOOP_OFF;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      loop_st    <= sfcd_pkg::SFCD_LOOP_OFF;
      relock_cnt <= '0;
    end else begin
      loop_st    <= next_loop_st;
      relock_cnt <= next_relock_cnt;
    end
  end

  // ------------------------------------------------------------------
  // Internal conversion clock
  // ------------------------------------------------------------------
  wire locked = (loop_st == sfcd_pkg::SFCD_LOOP_LOCKED);
  // Half period, rounded up, for the rebuilt falling edge
  wire [DIV_W:0] half_hi =
    (DIV_W+1)'(({1'b0, ratio_m1} + 2'd2) >> 1);
  wire           fixed_hi  = ({1'b0, phase} < half_hi); // RULE_05
  // Bypassed: high for one undivided input cycle per period, at phase zero
  wire           bypass_hi = rise; // RULE_06
  wire           next_conv = locked ? fixed_hi : bypass_hi; // RULE_05

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      conv_clk    <= 1'b0;
      sample_en   <= 1'b0;
      loop_locked <= 1'b0;
    end else begin
      conv_clk    <= next_conv;
      sample_en   <= rise; // RULE_09
      loop_locked <= locked;
    end
  end

  // ------------------------------------------------------------------
  // Read back
  // ------------------------------------------------------------------
  logic [sfcd_pkg::DATA_W-1:0] rd_mux;

  always_comb begin
    rd_mux = sfcd_pkg::UNMAPPED_READ;
    if (sel_duty) begin
      rd_mux = duty_fix;
      rd_mux[sfcd_pkg::DUTY_LOCK_BIT] = locked;
      rd_mux[sfcd_pkg::DUTY_ACT_BIT]  = loop_active;
    end else if (sel_div) begin
      rd_mux = clock_divide;
    end else if (sel_sync) begin
      rd_mux = sync_control;
      rd_mux[sfcd_pkg::SYNC_ARMED_BIT] = sync_armed;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata  <= '0;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_req.rd;
      if (reg_req.rd) begin
        reg_rdata <= rd_mux;
      end
    end
  end

endmodule

// file: verilog/sfcd_div.sv
/*
  Programmable integer clock divider with restart to initial state.
  Assumes ratio is held stable except when the owner restarts it.
*/
`timescale 1ns/10ps
module sfcd_div #(
  parameter int DIV_W = 3
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic [DIV_W-1:0] ratio_m1,
  input  wire logic             restart,
  output logic      [DIV_W-1:0] phase,
  output logic                  rise
);

  logic [DIV_W-1:0] next_phase;
  wire              wrap = (phase >= ratio_m1);

  // Initial state is phase zero; phase zero is the sampling edge
  assign next_phase = (restart || wrap) ? '0 : DIV_W'(phase + 1'b1); // RULE_04
  assign rise       = (phase == '0); // RULE_01

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      phase <= '0;
    end else begin
      phase <= next_phase; // RULE_01
    end
  end

endmodule
